// >>> pkg/octal_dac_params.svh
`ifndef OCTAL_DAC_PARAMS_SVH
`define OCTAL_DAC_PARAMS_SVH

// ----------------------------------------
// register map (byte addresses)
// ----------------------------------------
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_LASTWORD 8'h08
`define BANK_MISC 3'h0
`define BANK_DAC 3'h1
`define BANK_INPUT 3'h2
`define BANK_HI 7
`define BANK_LO 5
`define IDX_HI 4
`define IDX_LO 2

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define CTRL_REFINT 0
`define CTRL_CLR_HI 2
`define CTRL_CLR_LO 1
`define CTRL_WIDTH 3
`define CTRL_RST 3'h0
`define CMD_HI 27
`define CMD_LO 24
`define CH_HI 22
`define CH_LO 20
`define DATA_HI 15
`define DATA_LO 0
`define CMD_WRITE 4'h0
`define CMD_WRITE_UPD 4'h1

// ----------------------------------------
// codes and counts
// ----------------------------------------
`define CLR_ZERO 2'h0
`define CLR_MID 2'h1
`define CODE_ZERO 16'h0000
`define CODE_MID 16'h8000
`define CODE_FULL 16'hffff
`define BITS_PER_BYTE 4'h8
`define FIRST_TX_BIT 4'h1
`define LAST_BYTE 2'h3
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// >>> pkg/octal_dac_pkg.sv
`default_nettype none

package octal_dac_pkg;

    typedef logic [15:0] code_t;
    typedef logic [7:0][15:0] code_bank_t;

    typedef struct packed {
        logic scl;
        logic sda;
        logic loadN;
        logic clearN;
        logic addrLsb;
    } pins_t;

    typedef struct packed {
        logic [7:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [7:0] araddr;
        logic arvalid;
        logic rready;
    } axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } axi_rsp_t;

    typedef enum logic [2:0] {
        I2C_IDLE = 3'h0,
        I2C_ADDR = 3'h1,
        I2C_ACKA = 3'h3,
        I2C_DATA = 3'h2,
        I2C_ACKD = 3'h6,
        I2C_TXD = 3'h7,
        I2C_MACK = 3'h5,
        I2C_IGNORE = 3'h4
    } i2c_state_t;

    typedef struct packed {
        pins_t s1;
        pins_t s2;
        pins_t prev;
        i2c_state_t st;
        logic readMode;
        logic [3:0] bitCnt;
        logic [1:0] byteCnt;
        logic [7:0] shByte;
        logic [31:0] word;
        logic [31:0] txWord;
        logic sdaOut;
        logic sdaOeN;
        code_bank_t inReg;
        code_bank_t dacReg;
        logic [7:0] pend;
        logic [2:0] ctrl;
        logic awHave;
        logic [7:0] awAddr;
        logic wHave;
        logic [31:0] wData;
        logic [3:0] wStrb;
        axi_rsp_t rsp;
    } state_t;

endpackage

`default_nettype wire

// >>> rtl/octal_dac_pin_control.sv
// How it works
// - a low level on the load strobe copies every pending input register into its dac register.
// - the synchronised address-select pin is bit zero of the seven-bit bus target address.
// - a falling edge of the clear input, caught by its synchroniser, starts the clear action.
// - while the clear input is low no load strobe moves anything into the dac registers.
// - a clear loads input and dac registers of all channels with the selected clear code.
// - after reset the clear code selects zero scale.
// - words move in and out through a 32-bit shift path on the serial clock and data lines.
// - serial data is only ever pulled low or released, never driven high.
// - the reference pin is an input until software selects the internal reference.
// - eight channels each keep their own input register and dac register.
`timescale 1ns/1ps
`default_nettype none
`include "octal_dac_params.svh"

module octal_dac_pin_control #(
    parameter logic [5:0] DEV_ADDR_HI = 6'h0d
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic clkEn,
    // device pins
    input wire octal_dac_pkg::pins_t pinsIn,
    output logic sdaOut,
    output logic sdaOeN,
    output logic refOutEn,
    // converter codes
    output octal_dac_pkg::code_bank_t dacCode,
    // register bus
    input wire octal_dac_pkg::axi_req_t axiReq,
    output octal_dac_pkg::axi_rsp_t axiRsp
);
    import octal_dac_pkg::*;

    state_t s_reg;
    state_t s_next;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        logic sclRise;
        logic sclFall;
        logic startCond;
        logic stopCond;
        logic clearFall;
        logic doExec;
        logic loadOk;
        code_t clrCode;
        logic [3:0] cmd;
        logic [2:0] ch;
        logic [2:0] idx;
        loadOk = 1'b0;
        clrCode = `CODE_ZERO;
        s_next = s_reg;
        s_next.s1 = pinsIn;
        s_next.s2 = s_reg.s1;
        s_next.prev = s_reg.s2;
        sclRise = s_reg.s2.scl & ~s_reg.prev.scl;
        sclFall = ~s_reg.s2.scl & s_reg.prev.scl;
        startCond = s_reg.s2.scl & s_reg.prev.scl & s_reg.prev.sda & ~s_reg.s2.sda;
        stopCond = s_reg.s2.scl & s_reg.prev.scl & ~s_reg.prev.sda & s_reg.s2.sda;
        clearFall = s_reg.prev.clearN & ~s_reg.s2.clearN;
        doExec = 1'b0;
        cmd = s_reg.word[`CMD_HI:`CMD_LO];
        ch = s_reg.word[`CH_HI:`CH_LO];
        idx = axiReq.araddr[`IDX_HI:`IDX_LO];

        // ----------------------------------------
        // serial link
        // ----------------------------------------
        // open drain only
        s_next.sdaOut = 1'b0;
        if (startCond) begin
            s_next.st = I2C_ADDR;
            s_next.bitCnt = '0;
            s_next.byteCnt = '0;
            s_next.sdaOeN = 1'b1;
        end else if (stopCond) begin
            s_next.st = I2C_IDLE;
            s_next.bitCnt = '0;
            s_next.byteCnt = '0;
            s_next.sdaOeN = 1'b1;
        end else begin
            case (s_reg.st)
                I2C_IDLE, I2C_IGNORE: begin
                    s_next.sdaOeN = 1'b1;
                end
                I2C_ADDR, I2C_DATA: begin
                    if (sclRise && s_reg.bitCnt != `BITS_PER_BYTE) begin
                        s_next.shByte = {s_reg.shByte[6:0], s_reg.s2.sda};
                        s_next.bitCnt = s_reg.bitCnt + 4'h1;
                    end else if (sclFall && s_reg.bitCnt == `BITS_PER_BYTE) begin
                        if (s_reg.st == I2C_ADDR) begin
                            if (s_reg.shByte[7:1] == {DEV_ADDR_HI, s_reg.s2.addrLsb}) begin
                                s_next.sdaOeN = 1'b0;
                                s_next.readMode = s_reg.shByte[0];
                                s_next.txWord = s_reg.word;
                                s_next.st = I2C_ACKA;
                            end else begin
                                s_next.st = I2C_IGNORE;
                            end
                        end else begin
                            s_next.word = {s_reg.word[23:0], s_reg.shByte};
                            s_next.sdaOeN = 1'b0;
                            s_next.st = I2C_ACKD;
                        end
                    end
                end
                I2C_ACKA: begin
                    if (sclFall) begin
                        if (s_reg.readMode) begin
                            s_next.sdaOeN = s_reg.txWord[31];
                            s_next.txWord = {s_reg.txWord[30:0], 1'b0};
                            s_next.bitCnt = `FIRST_TX_BIT;
                            s_next.st = I2C_TXD;
                        end else begin
                            s_next.sdaOeN = 1'b1;
                            s_next.bitCnt = '0;
                            s_next.st = I2C_DATA;
                        end
                    end
                end
                I2C_ACKD: begin
                    if (sclFall) begin
                        s_next.sdaOeN = 1'b1;
                        s_next.bitCnt = '0;
                        s_next.st = I2C_DATA;
                        if (s_reg.byteCnt == `LAST_BYTE) begin
                            doExec = 1'b1;
                            s_next.byteCnt = '0;
                        end else begin
                            s_next.byteCnt = s_reg.byteCnt + 2'h1;
                        end
                    end
                end
                I2C_TXD: begin
                    if (sclFall) begin
                        if (s_reg.bitCnt == `BITS_PER_BYTE) begin
                            s_next.sdaOeN = 1'b1;
                            s_next.st = I2C_MACK;
                        end else begin
                            s_next.sdaOeN = s_reg.txWord[31];
                            s_next.txWord = {s_reg.txWord[30:0], 1'b0};
                            s_next.bitCnt = s_reg.bitCnt + 4'h1;
                        end
                    end
                end
                I2C_MACK: begin
                    if (sclRise && s_reg.s2.sda) begin
                        s_next.st = I2C_IGNORE;
                    end else if (sclFall) begin
                        s_next.sdaOeN = s_reg.txWord[31];
                        s_next.txWord = {s_reg.txWord[30:0], 1'b0};
                        s_next.bitCnt = `FIRST_TX_BIT;
                        s_next.st = I2C_TXD;
                    end
                end
                default: begin
                    s_next.st = I2C_IDLE;
                    s_next.sdaOeN = 1'b1;
                end
            endcase
        end

        // ----------------------------------------
        // channel registers
        // ----------------------------------------
        // clear code select
        case (s_reg.ctrl[`CTRL_CLR_HI:`CTRL_CLR_LO])
            `CLR_ZERO: clrCode = `CODE_ZERO;
            `CLR_MID: clrCode = `CODE_MID;
            default: clrCode = `CODE_FULL;
        endcase
        loadOk = ~s_reg.s2.loadN & s_reg.s2.clearN;
        for (int i = 0; i < 8; i++) begin
            if (clearFall) begin
                s_next.inReg[i] = clrCode;
                s_next.dacReg[i] = clrCode;
                s_next.pend[i] = 1'b0;
            end else begin
                if (loadOk && s_reg.pend[i]) begin
                    s_next.dacReg[i] = s_reg.inReg[i];
                    s_next.pend[i] = 1'b0;
                end
                if (doExec && ch == 3'(i)) begin
                    if (cmd == `CMD_WRITE) begin
                        s_next.inReg[i] = s_reg.word[`DATA_HI:`DATA_LO];
                        s_next.pend[i] = 1'b1;
                    end else if (cmd == `CMD_WRITE_UPD) begin
                        s_next.inReg[i] = s_reg.word[`DATA_HI:`DATA_LO];
                        s_next.dacReg[i] = s_reg.word[`DATA_HI:`DATA_LO];
                        s_next.pend[i] = 1'b0;
                    end
                end
            end
        end

        // ----------------------------------------
        // register bus write
        // ----------------------------------------
        if (axiReq.awvalid && s_reg.rsp.awready) begin
            s_next.awHave = 1'b1;
            s_next.awAddr = axiReq.awaddr;
        end
        if (axiReq.wvalid && s_reg.rsp.wready) begin
            s_next.wHave = 1'b1;
            s_next.wData = axiReq.wdata;
            s_next.wStrb = axiReq.wstrb;
        end
        if (s_reg.awHave && s_reg.wHave) begin
            s_next.awHave = 1'b0;
            s_next.wHave = 1'b0;
            s_next.rsp.bvalid = 1'b1;
            if (s_reg.awAddr == `REG_CTRL) begin
                if (s_reg.wStrb[0]) begin
                    s_next.ctrl = s_reg.wData[`CTRL_WIDTH-1:0];
                end
                s_next.rsp.bresp = `RESP_OKAY;
            end else begin
                s_next.rsp.bresp = `RESP_SLVERR;
            end
        end
        if (s_reg.rsp.bvalid && axiReq.bready) begin
            s_next.rsp.bvalid = 1'b0;
        end
        s_next.rsp.awready = ~s_next.awHave & ~s_next.rsp.bvalid;
        s_next.rsp.wready = ~s_next.wHave & ~s_next.rsp.bvalid;

        // ----------------------------------------
        // register bus read
        // ----------------------------------------
        if (s_reg.rsp.rvalid && axiReq.rready) begin
            s_next.rsp.rvalid = 1'b0;
        end
        if (axiReq.arvalid && s_reg.rsp.arready) begin
            s_next.rsp.rvalid = 1'b1;
            s_next.rsp.rresp = `RESP_OKAY;
            s_next.rsp.rdata = '0;
            case (axiReq.araddr[`BANK_HI:`BANK_LO])
                `BANK_MISC: begin
                    if (axiReq.araddr == `REG_CTRL) begin
                        s_next.rsp.rdata[`CTRL_WIDTH-1:0] = s_reg.ctrl;
                    end else if (axiReq.araddr == `REG_STATUS) begin
                        s_next.rsp.rdata[9:0] = {s_reg.s2.clearN, s_reg.s2.loadN, s_reg.pend};
                    end else if (axiReq.araddr == `REG_LASTWORD) begin
                        s_next.rsp.rdata = s_reg.word;
                    end else begin
                        s_next.rsp.rresp = `RESP_SLVERR;
                    end
                end
                `BANK_DAC: s_next.rsp.rdata[15:0] = s_reg.dacReg[idx];
                `BANK_INPUT: s_next.rsp.rdata[15:0] = s_reg.inReg[idx];
                default: s_next.rsp.rresp = `RESP_SLVERR;
            endcase
            if (axiReq.araddr[1:0] != 2'h0) begin
                s_next.rsp.rdata = '0;
                s_next.rsp.rresp = `RESP_SLVERR;
            end
        end
        s_next.rsp.arready = ~s_next.rsp.rvalid;
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            s_reg <= '0;
            s_reg.s1 <= '1;
            s_reg.s2 <= '1;
            s_reg.prev <= '1;
            s_reg.st <= I2C_IDLE;
            s_reg.sdaOeN <= 1'b1;
            s_reg.ctrl <= `CTRL_RST;
        end else if (clkEn) begin
            s_reg <= s_next;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign sdaOut = s_reg.sdaOut;
    assign sdaOeN = s_reg.sdaOeN;
    assign refOutEn = s_reg.ctrl[`CTRL_REFINT];
    assign dacCode = s_reg.dacReg;
    assign axiRsp = s_reg.rsp;

endmodule // octal_dac_pin_control

`default_nettype wire

// >>> sim/i2c_master_model.sv
`timescale 1ns/1ps
`default_nettype none

module i2c_master_model (
    // clock
    input wire logic ref_clk,
    // serial lines
    input wire logic sdaOeN,
    output logic scl,
    output logic sda
);
    logic mSda = 1'b1;

    initial scl = 1'b1;
    // open drain, pulled up when both release
    assign sda = mSda & sdaOeN;

    // quarter of the serial clock period
    task automatic q3();
        repeat (3) @(posedge ref_clk);
    endtask

    task automatic put_bit(input logic b, output logic s);
        mSda <= b;
        q3();
        scl <= 1'b1;
        q3();
        s = sda;
        q3();
        scl <= 1'b0;
        q3();
    endtask

    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            put_bit(b[i], s);
        end
        put_bit(1'b1, s);
        ack = !s;
    endtask

    task automatic frame(input logic [6:0] addr, input logic [31:0] w, output logic ok);
        logic a;
        mSda <= 1'b1;
        q3();
        scl <= 1'b1;
        q3();
        mSda <= 1'b0;
        q3();
        scl <= 1'b0;
        q3();
        put_byte({addr, 1'b0}, ok);
        for (int i = 3; i >= 0; i--) begin
            put_byte(w[i * 8 +: 8], a);
            ok = ok & a;
        end
        mSda <= 1'b0;
        q3();
        scl <= 1'b1;
        q3();
        mSda <= 1'b1;
        q3();
    endtask

    // word read back, nack on the last byte
    task automatic get_word(input logic [6:0] addr, output logic [31:0] w, output logic ok);
        logic s;
        mSda <= 1'b1;
        q3();
        scl <= 1'b1;
        q3();
        mSda <= 1'b0;
        q3();
        scl <= 1'b0;
        q3();
        put_byte({addr, 1'b1}, ok);
        for (int i = 31; i >= 0; i--) begin
            put_bit(1'b1, s);
            w[i] = s;
            if (i % 8 == 0) put_bit(i == 0, s);
        end
        mSda <= 1'b0;
        q3();
        scl <= 1'b1;
        q3();
        mSda <= 1'b1;
        q3();
    endtask
endmodule // i2c_master_model

`default_nettype wire

// >>> sim/octal_dac_pin_control_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "octal_dac_params.svh"

module octal_dac_pin_control_sva (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic clkEn,
    // pins and codes
    input wire octal_dac_pkg::pins_t pinsIn,
    input wire logic sdaOut,
    input wire logic sdaOeN,
    input wire logic refOutEn,
    input wire octal_dac_pkg::code_bank_t dacCode,
    // register bus
    input wire octal_dac_pkg::axi_req_t axiReq,
    input wire octal_dac_pkg::axi_rsp_t axiRsp
);
    import octal_dac_pkg::*;
    logic ctrlWr_reg;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    // any bus write is counted as one that may move the clear code
    always_ff @(posedge ref_clk) begin
        ctrlWr_reg <= rstn && (ctrlWr_reg || (axiReq.awvalid && axiRsp.awready));
    end

    property p_sda_low;
        sdaOut == 1'b0;
    endproperty
    a_sda_low: assert property (p_sda_low) else $error("sda driven high");
    property p_ack_in_low;
        $fell(sdaOeN) |-> !pinsIn.scl;
    endproperty
    a_ack_in_low: assert property (p_ack_in_low) else $error("sda pulled with scl high");
    property p_ref_by_bus;
        $changed(refOutEn) && $past(rstn) |-> axiRsp.bvalid || $past(axiRsp.bvalid);
    endproperty
    a_ref_by_bus: assert property (p_ref_by_bus) else $error("reference pin moved alone");
    property p_clear_same;
        $fell(pinsIn.clearN) ##1 !pinsIn.clearN [*7] |-> dacCode == {8{dacCode[0]}}
            && dacCode[0] inside {`CODE_ZERO, `CODE_MID, `CODE_FULL};
    endproperty
    a_clear_same: assert property (p_clear_same) else $error("clear code not loaded");
    property p_clear_zero;
        ($fell(pinsIn.clearN) && !ctrlWr_reg) ##1 !pinsIn.clearN [*7] |-> dacCode == '0;
    endproperty
    a_clear_zero: assert property (p_clear_zero) else $error("default clear not zero");
    property p_wr_answer;
        axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready |=> ##1 axiRsp.bvalid;
    endproperty
    a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
    property p_rd_answer;
        axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid && !axiRsp.arready;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
    property p_rd_unmapped;
        axiReq.arvalid && axiRsp.arready && axiReq.araddr == 8'h0c |=>
            axiRsp.rresp == `RESP_SLVERR && axiRsp.rdata == 32'h0000_0000;
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read accepted");
endmodule // octal_dac_pin_control_sva

bind octal_dac_pin_control octal_dac_pin_control_sva i_octal_dac_pin_control_sva (
    .ref_clk(ref_clk), .rstn(rstn), .clkEn(clkEn), .pinsIn(pinsIn), .sdaOut(sdaOut),
    .sdaOeN(sdaOeN), .refOutEn(refOutEn), .dacCode(dacCode), .axiReq(axiReq), .axiRsp(axiRsp)
);

`default_nettype wire

// >>> sim/octal_dac_pin_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "octal_dac_params.svh"

module octal_dac_pin_control_tb_top;
    import octal_dac_pkg::*;
    localparam logic [5:0] ADDR_HI = 6'h15;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic loadN = 1'b1;
    logic clearN = 1'b1;
    logic addrLsb = 1'b1;
    logic scl;
    logic sda;
    logic sdaOeN;
    logic refOutEn;
    code_bank_t dacCode;
    axi_req_t req = '0;
    axi_rsp_t rsp;
    pins_t pins;
    logic [33:0] notes[$];
    logic [33:0] e;
    logic [7:0] lastAr;
    logic [15:0] cv[8];
    logic ok;
    logic clkEn = 1'b1;
    logic [31:0] rw;
    int errors = 0;
    int nTests = 0;

    always #2 ref_clk = ~ref_clk;
    assign pins = {scl, sda, loadN, clearN, addrLsb};

    octal_dac_pin_control #(.DEV_ADDR_HI(ADDR_HI)) i_octal_dac_pin_control (
        .ref_clk(ref_clk), .rstn(rstn), .clkEn(clkEn), .pinsIn(pins), .sdaOut(),
        .sdaOeN(sdaOeN), .refOutEn(refOutEn), .dacCode(dacCode), .axiReq(req), .axiRsp(rsp)
    );
    i2c_master_model i_i2c_master_model (.ref_clk(ref_clk), .sdaOeN(sdaOeN), .scl(scl), .sda(sda));

    task automatic report_and_stop();
        if (errors == 0 && nTests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        nTests++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [1:0] r);
        int n;
        notes.push_back({r, wr ? 32'h0000_0000 : d});
        req.awaddr <= a;
        req.araddr <= a;
        req.wdata <= d;
        req.wstrb <= 4'hf;
        req.awvalid <= wr;
        req.wvalid <= wr;
        req.bready <= wr;
        req.arvalid <= !wr;
        req.rready <= !wr;
        for (n = 0; n < 40; n++) begin
            @(posedge ref_clk);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
            if (rsp.arready) req.arvalid <= 1'b0;
            if (rsp.bvalid || rsp.rvalid) break;
        end
        req.bready <= 1'b0;
        req.rready <= 1'b0;
        @(posedge ref_clk);
        if (n == 40) begin
            errors++;
            report_and_stop();
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] c);
        axi(1'b0, a, {16'h0000, c}, `RESP_OKAY);
    endtask

    task automatic wr_word(input logic lsb, input logic [3:0] cmd, input logic [2:0] ch,
                           input logic [15:0] c, input logic expOk);
        i_i2c_master_model.frame({ADDR_HI, lsb}, {4'h0, cmd, 1'b0, ch, 4'h0, c}, ok);
        chk({33'h0, ok}, {33'h0, expOk});
        repeat (8) @(posedge ref_clk);
    endtask

    task automatic pulse(input logic isClear);
        if (isClear) clearN <= 1'b0;
        else loadN <= 1'b0;
        repeat (12) @(posedge ref_clk);
        clearN <= 1'b1;
        loadN <= 1'b1;
        repeat (6) @(posedge ref_clk);
    endtask

    // -----------------------------
    // result watcher
    // -----------------------------
    always @(posedge ref_clk) begin
        if (req.arvalid && rsp.arready) lastAr <= req.araddr;
        if (rsp.rvalid && req.rready) begin
            e = notes.pop_front();
            chk({rsp.rresp, rsp.rdata}, e);
            if (lastAr[7:5] == 3'h1) chk({18'h0, dacCode[lastAr[4:2]]}, e);
        end
        if (rsp.bvalid && req.bready) chk({rsp.bresp, 32'h0000_0000}, notes.pop_front());
    end

    initial begin
        void'($urandom(65));
        repeat (5) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge ref_clk);
        for (int i = 0; i < 8; i++) begin
            cv[i] = 16'($urandom);
            wr_word(1'b1, `CMD_WRITE, 3'(i), cv[i], 1'b1);
            rd(8'h40 + 8'(4 * i), cv[i]);
            rd(8'h20 + 8'(4 * i), 16'h0000);
        end
        axi(1'b0, `REG_LASTWORD, {8'h00, 1'b0, 3'h7, 4'h0, cv[7]}, `RESP_OKAY);
        wr_word(1'b0, `CMD_WRITE_UPD, 3'h0, 16'h1234, 1'b0);
        pulse(1'b0);
        for (int i = 0; i < 8; i++) begin
            rd(8'h20 + 8'(4 * i), cv[i]);
        end
        clearN <= 1'b0;
        repeat (10) @(posedge ref_clk);
        wr_word(1'b1, `CMD_WRITE, 3'h2, cv[5], 1'b1);
        pulse(1'b0);
        rd(8'h28, 16'h0000);
        rd(8'h48, cv[5]);
        rd(8'h54, 16'h0000);
        clkEn <= 1'b0;
        loadN <= 1'b0;
        repeat (6) @(posedge ref_clk);
        loadN <= 1'b1;
        repeat (6) @(posedge ref_clk);
        clkEn <= 1'b1;
        repeat (6) @(posedge ref_clk);
        rd(8'h28, 16'h0000);
        pulse(1'b0);
        rd(8'h28, cv[5]);
        rd(`REG_CTRL, 16'h0000);
        axi(1'b1, `REG_CTRL, 32'h0000_0001, `RESP_OKAY);
        chk({33'h0, refOutEn}, 34'h1);
        axi(1'b1, 8'h0c, 32'hffff_ffff, `RESP_SLVERR);
        axi(1'b0, 8'h0c, 32'h0000_0000, `RESP_SLVERR);
        rd(`REG_CTRL, 16'h0001);
        for (int s = 1; s < 4; s++) begin
            axi(1'b1, `REG_CTRL, 32'(2 * s + 1), `RESP_OKAY);
            pulse(1'b1);
            rd(8'h3c, (s == 1) ? `CODE_MID : `CODE_FULL);
            rd(8'h40, (s == 1) ? `CODE_MID : `CODE_FULL);
        end
        addrLsb <= 1'b0;
        loadN <= 1'b0;
        repeat (6) @(posedge ref_clk);
        wr_word(1'b0, `CMD_WRITE, 3'h3, cv[1], 1'b1);
        rd(8'h2c, cv[1]);
        loadN <= 1'b1;
        repeat (6) @(posedge ref_clk);
        wr_word(1'b0, `CMD_WRITE_UPD, 3'h6, cv[4], 1'b1);
        rd(8'h38, cv[4]);
        i_i2c_master_model.get_word({ADDR_HI, 1'b0}, rw, ok);
        chk({33'h0, ok}, 34'h1);
        chk({2'h0, rw}, {2'h0, 4'h0, `CMD_WRITE_UPD, 1'b0, 3'h6, 4'h0, cv[4]});
        report_and_stop();
    end
endmodule // octal_dac_pin_control_tb_top

`default_nettype wire
